// *** src/pcr_pkg.sv ***
// shared constants and carrier types for the port configuration / partner page block
package pcr_pkg;

  // ==========================================================
  // management frame layout
  localparam logic [4:0] REG_PARTNER_NP  = 5'h08;
  localparam logic [4:0] REG_PORT_CFG    = 5'h10;
  localparam logic [1:0] OP_READ         = 2'h2;
  localparam logic [1:0] OP_WRITE        = 2'h1;
  localparam int         PREAMBLE_LEN    = 32;
  localparam int         HDR_BITS        = 13;
  localparam int         DATA_BITS       = 16;
  localparam int         TA_BITS         = 2;
  localparam logic [4:0] HDR_LAST        = 5'(HDR_BITS - 1);
  localparam logic [4:0] DATA_LAST       = 5'(DATA_BITS - 1);
  localparam logic [4:0] SKIP_LAST       = 5'(TA_BITS + DATA_BITS - 1);
  localparam int         HDR_ST_BIT      = 12;
  localparam int         HDR_OP_HI       = 11;
  localparam int         HDR_OP_LO       = 10;
  localparam int         HDR_PHY_HI      = 9;
  localparam int         HDR_PHY_LO      = 5;
  localparam int         HDR_REG_HI      = 4;
  localparam logic [5:0] PRE_CNT_MAX     = 6'h3f;

  // ==========================================================
  // register reset values and masks
  localparam logic [15:0] CFG_RESET      = 16'h0084;
  localparam logic [15:0] CFG_WR_MASK    = 16'h7faf;
  localparam logic [15:0] NP_RESET       = 16'h0000;
  localparam logic [15:0] READ_UNMAPPED  = 16'h0000;

  typedef struct packed {
    logic        reserved15;
    logic        linkTestDisable;
    logic        txDisable;
    logic        scramblerBypass;
    logic        coderBypass;
    logic        jabberDisable;
    logic        sqeEnable;
    logic        tpLoopbackOff;
    logic        crsSelect;
    logic        reserved6;
    logic        preambleEnable;
    logic        reserved4;
    logic        serialMode;
    logic        farEndFaultEn;
    logic        altNextPage;
    logic        fiberSelect;
  } pcr_cfg_t;

  typedef struct packed {
    logic        nextPage;
    logic        ack;
    logic        messagePage;
    logic        ack2;
    logic        toggle;
    logic [10:0] code;
  } pcr_np_t;

  // qualified controls that steer the port datapath
  typedef struct packed {
    logic linkPass;
    logic txEnable;
    logic scramblerBypass;
    logic coderBypass;
    logic jabberEnable;
    logic sqeEnable;
    logic tpLoopback;
    logic crsExtend;
    logic preambleDeliver;
    logic serialMode;
    logic farEndFaultEn;
    logic altNextPage;
    logic fiberMode;
  } pcr_ctrl_t;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_HDR  = 5'b00010,
    ST_TA   = 5'b00100,
    ST_DATA = 5'b01000,
    ST_SKIP = 5'b10000
  } pcr_state_t;

endpackage : pcr_pkg

// *** src/pcr_port_regs.sv ***
// management-reachable partner next page and port configuration registers of one port
`timescale 1ns/1ps
`default_nettype none

module pcr_port_regs
  import pcr_pkg::*;
#(
  parameter int PREAMBLE_MIN = pcr_pkg::PREAMBLE_LEN
)(
  input  wire logic              clock,
  input  wire logic              nrst,
  input  wire logic [4:0]        phyAddr,
  input  wire logic              strapFiber,
  input  wire logic              mdc,
  input  wire logic              mdioIn,
  output logic                   mdioOut,
  output logic                   mdioOe,
  input  wire logic              npLoad,
  input  wire pcr_pkg::pcr_np_t  npWord,
  input  wire logic              mrPageRx,
  input  wire logic              linkRaw,
  input  wire logic              speed100,
  input  wire logic              fullDuplex,
  output pcr_pkg::pcr_cfg_t      cfgOut,
  output pcr_pkg::pcr_ctrl_t     ctrlOut,
  output logic                   pageReceived
);
  import pcr_pkg::*;

  // ==========================================================
  // parameter checks
  // the preamble counter saturates at its top code, so longer preambles still qualify
  if (PREAMBLE_MIN < 1 || PREAMBLE_MIN > int'(PRE_CNT_MAX))
  begin : g_bad_preamble
    $error("PREAMBLE_MIN must lie in 1..63");
  end

  localparam logic [5:0] PRE_MIN = 6'(PREAMBLE_MIN);

  // ==========================================================
  // state
  pcr_state_t  state_reg,   state_next;
  logic [5:0]  preCnt_reg,  preCnt_next;
  logic [4:0]  bitCnt_reg,  bitCnt_next;
  logic [15:0] shift_reg,   shift_next;
  logic        isRead_reg,  isRead_next;
  logic [4:0]  regAddr_reg, regAddr_next;
  logic        mdioOut_reg, mdioOut_next;
  logic        mdioOe_reg,  mdioOe_next;
  logic        mdcPrev_reg;
  pcr_cfg_t    cfg_reg,     cfg_next;
  pcr_np_t     np_reg,      np_next;
  pcr_ctrl_t   ctrl_reg,    ctrl_next;
  logic        pageRx_reg,  pageRx_next;

  logic        mdcRise;
  logic [12:0] hdr;
  logic [15:0] rdData;
  logic [15:0] wrData;
  logic        hdrStart;
  logic [1:0]  hdrOp;
  logic [4:0]  hdrPhy;
  logic [4:0]  hdrReg;
  logic        hdrLegalOp;

  // ==========================================================
  // edge detect and header decode
  assign mdcRise = mdc & ~mdcPrev_reg;
  assign hdr     = {shift_reg[HDR_BITS-2:0], mdioIn};
  assign wrData  = {shift_reg[14:0], mdioIn};

  // header fields by name: the bits shifted in so far plus the one on the line now
  assign hdrStart   = hdr[HDR_ST_BIT];
  assign hdrOp      = hdr[HDR_OP_HI:HDR_OP_LO];
  assign hdrPhy     = hdr[HDR_PHY_HI:HDR_PHY_LO];
  assign hdrReg     = hdr[HDR_REG_HI:0];
  assign hdrLegalOp = (hdrOp == OP_READ) || (hdrOp == OP_WRITE);

  // ==========================================================
  // read data mux
  // reserved bits are never stored, so they read back as zero whatever was written
  always_comb
  begin
    unique case (regAddr_reg)
      REG_PARTNER_NP: rdData = np_reg;
      REG_PORT_CFG:   rdData = cfg_reg & CFG_WR_MASK;
      default:        rdData = READ_UNMAPPED;
    endcase
  end

  // ==========================================================
  // management frame engine and register writes
  always_comb
  begin
    state_next   = state_reg;
    preCnt_next  = preCnt_reg;
    bitCnt_next  = bitCnt_reg;
    shift_next   = shift_reg;
    isRead_next  = isRead_reg;
    regAddr_next = regAddr_reg;
    mdioOut_next = mdioOut_reg;
    mdioOe_next  = mdioOe_reg;
    cfg_next     = cfg_reg;
    if (mdcRise)
    begin
      unique case (state_reg)
        ST_IDLE:
        begin
          if (mdioIn)
            preCnt_next = (preCnt_reg == PRE_CNT_MAX) ? preCnt_reg : preCnt_reg + 6'h01;
          else
          begin
            // a zero after enough ones is the first start bit
            if (preCnt_reg >= PRE_MIN)
            begin
              state_next  = ST_HDR;
              bitCnt_next = '0;
            end
            preCnt_next = '0;
          end
        end
        ST_HDR:
        begin
          shift_next  = {shift_reg[14:0], mdioIn};
          bitCnt_next = bitCnt_reg + 5'h01;
          if (bitCnt_reg == HDR_LAST)
          begin
            bitCnt_next  = '0;
            regAddr_next = hdrReg;
            isRead_next  = (hdrOp == OP_READ);
            if (hdrStart && hdrPhy == phyAddr && hdrLegalOp)
              state_next = ST_TA;
            else
              state_next = ST_SKIP;   // a frame for another port's address, bad start bit or bad opcode: sit it out
          end
        end
        ST_TA:
        begin
          bitCnt_next = bitCnt_reg + 5'h01;
          if (bitCnt_reg == '0)
          begin
            // on a read the station has let go of the line; take it over with a zero
            mdioOe_next  = isRead_reg;
            mdioOut_next = 1'b0;
          end
          else
          begin
            state_next  = ST_DATA;
            bitCnt_next = '0;
            if (isRead_reg)
            begin
              mdioOut_next = rdData[15];
              shift_next   = {rdData[14:0], 1'b0};
            end
          end
        end
        ST_DATA:
        begin
          bitCnt_next = bitCnt_reg + 5'h01;
          if (isRead_reg)
          begin
            // most significant bit first, one bit per mdc period
            mdioOut_next = shift_reg[15];
            shift_next   = {shift_reg[14:0], 1'b0};
          end
          else
            shift_next = wrData;
          if (bitCnt_reg == DATA_LAST)
          begin
            state_next  = ST_IDLE;
            mdioOe_next = 1'b0;
            preCnt_next = '0;
            // the partner page register takes no write at all
            if (!isRead_reg && regAddr_reg == REG_PORT_CFG)
              cfg_next = pcr_cfg_t'(wrData & CFG_WR_MASK);
          end
        end
        // turnaround and data of a frame meant for another port or with a bad start bit or opcode
        ST_SKIP:
        begin
          bitCnt_next = bitCnt_reg + 5'h01;
          if (bitCnt_reg == SKIP_LAST)
          begin
            state_next  = ST_IDLE;
            preCnt_next = '0;
          end
        end
        default:
          state_next = ST_IDLE;
      endcase
    end
  end

  // ==========================================================
  // partner page capture and page-received flag
  always_comb
  begin
    // the page word is kept as received; its fields are the partner's to define
    np_next     = npLoad ? npWord : np_reg;
    pageRx_next = pageRx_reg;
    if (cfg_reg.altNextPage && (!mrPageRx || cfg_reg.txDisable))
      pageRx_next = 1'b0;
    // a new page in the clearing cycle must not be lost
    if (npLoad)
      pageRx_next = 1'b1;
  end

  // ==========================================================
  // qualified datapath controls
  // registered one clock behind the config so the datapath sees glitch-free levels
  always_comb
  begin
    ctrl_next.linkPass        = linkRaw | cfg_reg.linkTestDisable;
    ctrl_next.txEnable        = ~cfg_reg.txDisable;
    ctrl_next.scramblerBypass = speed100 & ~cfg_reg.fiberSelect
                                & cfg_reg.scramblerBypass;
    ctrl_next.coderBypass     = speed100 & cfg_reg.coderBypass;
    ctrl_next.jabberEnable    = ~speed100 & ~cfg_reg.jabberDisable;
    ctrl_next.sqeEnable       = ~speed100 & cfg_reg.sqeEnable;
    ctrl_next.tpLoopback      = ~speed100 & ~fullDuplex
                                & ~cfg_reg.tpLoopbackOff;
    ctrl_next.crsExtend       = ~speed100 & cfg_reg.crsSelect;
    ctrl_next.preambleDeliver = cfg_reg.preambleEnable;
    ctrl_next.serialMode      = ~speed100 & cfg_reg.serialMode;
    ctrl_next.farEndFaultEn   = cfg_reg.farEndFaultEn;
    ctrl_next.altNextPage     = cfg_reg.altNextPage;
    ctrl_next.fiberMode       = cfg_reg.fiberSelect;
  end

  // ==========================================================
  // registers
  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      state_reg   <= ST_IDLE;
      preCnt_reg  <= '0;
      bitCnt_reg  <= '0;
      shift_reg   <= '0;
      isRead_reg  <= 1'b0;
      regAddr_reg <= '0;
      mdioOut_reg <= 1'b0;
      mdioOe_reg  <= 1'b0;
      // follow the pin through reset so a line left high is not seen as a fresh rise
      mdcPrev_reg <= mdc;
      // synchronous reset, so the strap is sampled on the clock edge
      cfg_reg     <= pcr_cfg_t'({CFG_RESET[15:1], strapFiber});
      np_reg      <= pcr_np_t'(NP_RESET);
      ctrl_reg    <= '0;
      pageRx_reg  <= 1'b0;
    end
    else
    begin
      state_reg   <= state_next;
      preCnt_reg  <= preCnt_next;
      bitCnt_reg  <= bitCnt_next;
      shift_reg   <= shift_next;
      isRead_reg  <= isRead_next;
      regAddr_reg <= regAddr_next;
      mdioOut_reg <= mdioOut_next;
      mdioOe_reg  <= mdioOe_next;
      mdcPrev_reg <= mdc;
      cfg_reg     <= cfg_next;
      np_reg      <= np_next;
      ctrl_reg    <= ctrl_next;
      pageRx_reg  <= pageRx_next;
    end
  end

  // ==========================================================
  // outputs, each straight from its flip-flop
  assign mdioOut      = mdioOut_reg;
  assign mdioOe       = mdioOe_reg;
  assign cfgOut       = cfg_reg;
  assign ctrlOut      = ctrl_reg;
  assign pageReceived = pageRx_reg;

endmodule : pcr_port_regs

`default_nettype wire

// *** verification/pcr_mdio_station.sv ***
// management station model driving frames on the mdio line
`timescale 1ns/1ps
`default_nettype none
module pcr_mdio_station
  import pcr_pkg::*;
(
  input  wire logic clock,
  output logic      mdc,
  input  wire logic mdioOut,
  input  wire logic mdioOe,
  output logic      mdioWire
);
  // ==========
  // line model
  logic drv = 1'b0;
  logic val = 1'b1;
  int   half = 2;
  // pull-up: a released line reads high
  assign mdioWire = mdioOe ? mdioOut : (drv ? val : 1'b1);
  initial mdc = 1'b0;

  task automatic cyc(input logic en, input logic b, output logic s);
    drv = en;
    val = b;
    mdc = 1'b0;
    repeat (half) @(posedge clock);
    #1;
    s = mdioWire;
    mdc = 1'b1;
    repeat (half) @(posedge clock);
    #1;
  endtask : cyc

  task automatic frame(input logic [4:0] phy, input logic [1:0] op, input logic [4:0] ra,
                       input logic [15:0] wd, output logic [15:0] rd);
    logic [63:0] v;
    logic        s;
    v = {32'hffffffff, 2'b01, op, phy, ra, 2'b10, wd};
    for (int i = 63; i >= 0; i--)
    begin
      cyc(op == OP_WRITE || i >= 18, v[i], s);
      if (i < 16)
        rd[i] = s;
    end
    cyc(1'b0, 1'b1, s);
  endtask : frame
endmodule : pcr_mdio_station
`default_nettype wire

// *** verification/pcr_port_regs_chk.sv ***
// assertion checker for the port register block
`timescale 1ns/1ps
`default_nettype none
module pcr_port_regs_chk
  import pcr_pkg::*;
(
  input wire logic               clock,
  input wire logic               nrst,
  input wire logic               strapFiber,
  input wire logic               npLoad,
  input wire logic               mrPageRx,
  input wire logic               linkRaw,
  input wire logic               speed100,
  input wire logic               fullDuplex,
  input wire pcr_pkg::pcr_cfg_t  cfgOut,
  input wire pcr_pkg::pcr_ctrl_t ctrlOut,
  input wire logic               pageReceived
);
  // ==========
  // properties
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  sequence s_load;
    npLoad;
  endsequence
  sequence s_clear;
    !npLoad && cfgOut.altNextPage && (!mrPageRx || cfgOut.txDisable);
  endsequence
  chk_page_set: assert property (s_load |=> pageReceived)
    else $error("page flag not set by load");
  chk_page_clear: assert property (s_clear |=> !pageReceived)
    else $error("page flag not cleared");
  chk_page_hold: assert property (pageReceived && !cfgOut.altNextPage |=> pageReceived)
    else $error("page flag dropped");
  chk_link_pass: assert property ($past(nrst) |->
    ctrlOut.linkPass == ($past(linkRaw) | $past(cfgOut.linkTestDisable)))
    else $error("link pass wrong");
  chk_tx_off: assert property ($past(nrst) |-> ctrlOut.txEnable == !$past(cfgOut.txDisable))
    else $error("transmit enable wrong");
  chk_loop_qual: assert property ($past(nrst) |-> ctrlOut.tpLoopback ==
    (!$past(speed100) && !$past(fullDuplex) && !$past(cfgOut.tpLoopbackOff)))
    else $error("loopback wrong");
  chk_serial_qual: assert property ($past(nrst) |->
    ctrlOut.serialMode == ($past(cfgOut.serialMode) && !$past(speed100)))
    else $error("serial mode wrong");
  chk_strap_load: assert property ($rose(nrst) |-> cfgOut.fiberSelect == $past(strapFiber))
    else $error("strap not latched");
  chk_cfg_reset: assert property ($rose(nrst) |-> cfgOut[15:1] == 15'h0042)
    else $error("config reset value wrong");
endmodule : pcr_port_regs_chk

bind pcr_port_regs pcr_port_regs_chk pcr_port_regs_chk_i (.clock(clock), .nrst(nrst),
  .strapFiber(strapFiber), .npLoad(npLoad), .mrPageRx(mrPageRx), .linkRaw(linkRaw),
  .speed100(speed100), .fullDuplex(fullDuplex), .cfgOut(cfgOut), .ctrlOut(ctrlOut),
  .pageReceived(pageReceived));
`default_nettype wire

// *** verification/testbench.sv ***
// self-checking bench for the port register block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import pcr_pkg::*;
  // ==========
  // wiring
  localparam logic [4:0] PHY = 5'h05;
  localparam int         LIMIT = 40000;
  logic        clock = 1'b0;
  logic        nrst = 1'b0;
  logic        strapFiber = 1'b1;
  logic        mdc;
  logic        mdioIn;
  logic        mdioOut;
  logic        mdioOe;
  logic        npLoad = 1'b0;
  pcr_np_t     npWord = '0;
  logic        mrPageRx = 1'b1;
  logic        linkRaw = 1'b0;
  logic        speed100 = 1'b0;
  logic        fullDuplex = 1'b0;
  pcr_cfg_t    cfgOut;
  pcr_ctrl_t   ctrlOut;
  logic        pageReceived;
  int          error_cnt = 0;
  int          comparisons = 0;
  logic [15:0] d;
  always #2 clock = ~clock;
  pcr_port_regs pcr_port_regs_i (.clock(clock), .nrst(nrst), .phyAddr(PHY),
    .strapFiber(strapFiber), .mdc(mdc), .mdioIn(mdioIn), .mdioOut(mdioOut), .mdioOe(mdioOe),
    .npLoad(npLoad), .npWord(npWord), .mrPageRx(mrPageRx), .linkRaw(linkRaw),
    .speed100(speed100), .fullDuplex(fullDuplex), .cfgOut(cfgOut), .ctrlOut(ctrlOut),
    .pageReceived(pageReceived));
  pcr_mdio_station pcr_mdio_station_i (.clock(clock), .mdc(mdc), .mdioOut(mdioOut),
    .mdioOe(mdioOe), .mdioWire(mdioIn));
  // ==========
  // helpers and scenarios
  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    comparisons++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check
  task automatic mg(input logic [1:0] op, input logic [4:0] ra, input logic [15:0] wd);
    pcr_mdio_station_i.frame(PHY, op, ra, wd, d);
  endtask : mg
  task automatic ctl(input logic [12:0] exp);
    repeat (2) @(posedge clock);
    #1;
    check({3'h0, ctrlOut}, {3'h0, exp}, "controls");
  endtask : ctl
  task automatic load(input logic [15:0] w);
    npWord = w;
    npLoad = 1'b1;
    @(posedge clock);
    #1;
    npLoad = 1'b0;
    npWord = ~w;
    check({15'h0, pageReceived}, 16'h0001, "flag set");
  endtask : load
  task automatic t_cfg;
    mg(OP_READ, REG_PORT_CFG, 16'h0);
    check(d, 16'h0085, "cfg reset");
    mg(OP_READ, REG_PARTNER_NP, 16'h0);
    check(d, 16'h0000, "page reset");
    mg(OP_WRITE, REG_PORT_CFG, 16'h7faf);
    mg(OP_READ, REG_PORT_CFG, 16'h0);
    check(d, 16'h7faf, "cfg set");
    ctl(13'h10bf);
    speed100 = 1'b1;
    ctl(13'h1217);
    mg(OP_WRITE, REG_PORT_CFG, 16'h1800);
    ctl(13'h0e00);
    mg(OP_WRITE, REG_PORT_CFG, 16'h0000);
    speed100 = 1'b0;
    ctl(13'h0940);
    linkRaw = 1'b1;
    fullDuplex = 1'b1;
    ctl(13'h1900);
    linkRaw = 1'b0;
    fullDuplex = 1'b0;
    $display("config test done");
  endtask : t_cfg
  task automatic t_np;
    load(16'ha955);
    mg(OP_READ, REG_PARTNER_NP, 16'h0);
    check(d, 16'ha955, "page a");
    mg(OP_WRITE, REG_PARTNER_NP, 16'h1234);
    mg(OP_READ, REG_PARTNER_NP, 16'h0);
    check(d, 16'ha955, "page kept");
    load(16'h56aa);
    mg(OP_READ, REG_PARTNER_NP, 16'h0);
    check(d, 16'h56aa, "page b");
    $display("page test done");
  endtask : t_np
  task automatic t_alt;
    mrPageRx = 1'b0;
    repeat (3) @(posedge clock);
    #1;
    check({15'h0, pageReceived}, 16'h0001, "flag kept");
    mg(OP_WRITE, REG_PORT_CFG, 16'h0002);
    check({15'h0, pageReceived}, 16'h0000, "flag off");
    mrPageRx = 1'b1;
    load(16'h0001);
    mg(OP_WRITE, REG_PORT_CFG, 16'h2002);
    check({15'h0, pageReceived}, 16'h0000, "flag off tx");
    $display("alternate page test done");
  endtask : t_alt
  task automatic t_refuse;
    pcr_mdio_station_i.frame(PHY ^ 5'h01, OP_READ, REG_PORT_CFG, 16'h0, d);
    check(d, 16'hffff, "other phy");
    mg(OP_WRITE, 5'h11, 16'h0000);
    pcr_mdio_station_i.half = 5;
    mg(OP_READ, REG_PORT_CFG, 16'h0);
    check(d, 16'h2002, "cfg kept");
    mg(OP_READ, 5'h11, 16'h0);
    check(d, 16'h0000, "unmapped");
    $display("refusal test done");
  endtask : t_refuse
  task automatic t_reset;
    mg(OP_WRITE, REG_PORT_CFG, 16'h4000);
    load(16'hffff);
    nrst = 1'b0;
    repeat (4) @(posedge clock);
    #1;
    nrst = 1'b1;
    check({15'h0, pageReceived}, 16'h0000, "flag after reset");
    check(cfgOut, 16'h0084, "cfg strap low");
    mg(OP_READ, REG_PARTNER_NP, 16'h0);
    check(d, 16'h0000, "page after reset");
    mg(OP_READ, REG_PORT_CFG, 16'h0);
    check(d, 16'h0084, "cfg read after reset");
    ctl(13'h0964);
    $display("reset test done");
  endtask : t_reset
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : close_out
  initial
  begin
    repeat (LIMIT) @(posedge clock);
    error_cnt++;
    $display("CHECK FAILED at %0t: watchdog", $time);
    close_out;
  end
  initial
  begin
    repeat (12) @(posedge clock);
    #1;
    nrst = 1'b1;
    strapFiber = 1'b0;
    @(posedge clock);
    #1;
    t_cfg;
    t_np;
    t_alt;
    t_refuse;
    t_reset;
    close_out;
  end
endmodule : testbench
`default_nettype wire
